// file: common/dpmc_pkg.sv
package dpmc_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TMR_UNIT_MS = 1;
  localparam int unsigned TMR_UNIT_CYC = TMR_UNIT_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CMD = 5'h04;
  localparam logic [4:0] OFF_TMR = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0c;
  localparam logic [4:0] OFF_CHECK = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_SOFT_RST = 0;
  localparam int unsigned CMD_PEND = 8;
  localparam int unsigned SB_BUSY = 0;
  localparam int unsigned SB_READY = 1;
  localparam int unsigned SB_SEEK = 2;
  localparam int unsigned SB_IFACE = 3;
  localparam int unsigned SB_MEDIA = 4;
  localparam int unsigned SB_UNLOADED = 5;
  localparam int unsigned SB_TIMER = 6;
  localparam int unsigned SB_MODE = 8;
  localparam logic [7:0] TMR_RST = 8'h00;
  localparam logic [7:0] CHK_RST = 8'h00;

  // ----------------------------------------
  // host commands and check answers
  // ----------------------------------------
  localparam logic [7:0] CMD_STBY_IMM = 8'he0;
  localparam logic [7:0] CMD_IDLE_IMM = 8'he1;
  localparam logic [7:0] CMD_STBY = 8'he2;
  localparam logic [7:0] CMD_IDLE = 8'he3;
  localparam logic [7:0] CMD_CHECK = 8'he5;
  localparam logic [7:0] CMD_SLEEP = 8'he6;
  localparam logic [7:0] CHK_STBY = 8'h00;
  localparam logic [7:0] CHK_TO_STBY = 8'h01;
  localparam logic [7:0] CHK_FROM_STBY = 8'h02;
  localparam logic [7:0] CHK_IDLE = 8'h80;
  localparam logic [7:0] CHK_ACTIVE = 8'hff;

  // ----------------------------------------
  // power modes and sequencer states
  // ----------------------------------------
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_STBY = 2'h2;
  localparam logic [1:0] MODE_SLEEP = 2'h3;

  typedef enum logic [3:0] {
    ST_BOOT, ST_IDLE, ST_ACTIVE, ST_STBY, ST_SPINUP, ST_IUNLOAD, ST_FLUSH,
    ST_UNLOAD, ST_FLAGS, ST_BRAKE, ST_SPIN_WAIT, ST_POST, ST_SLEEP
  } dpmc_state_t;
endpackage

// file: logic/dpmc_tmr.sv
`timescale 1ns/10ps
module dpmc_tmr
  import dpmc_pkg::*;
#(
  parameter int unsigned UNIT_CYC = TMR_UNIT_CYC
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic load,
  input wire logic [7:0] count,
  input wire logic run,
  // event
  output logic expired
);
  localparam int unsigned PW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
  localparam logic [PW-1:0] PRE_TOP = PW'(UNIT_CYC - 1);

  if (UNIT_CYC < 1) $error("timer unit must be at least one cycle");

  logic [7:0] cnt_q, cnt_d, rem_q, rem_d;
  logic [PW-1:0] pre_q, pre_d;
  logic exp_q, exp_d;

  // remaining count reloads whenever the timer is not running
  always_comb
  begin
    cnt_d = load ? count : cnt_q;
    rem_d = rem_q;
    pre_d = pre_q;
    exp_d = 1'b0;
    if (!run || load)
    begin
      rem_d = cnt_d;
      pre_d = PRE_TOP;
    end
    else if (rem_q != 8'h00)
    begin
      if (pre_q == '0)
      begin
        pre_d = PRE_TOP;
        rem_d = rem_q - 8'h01;
        exp_d = (rem_q == 8'h01);
      end
      else
        pre_d = pre_q - PW'(1);
    end
  end

  // state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= TMR_RST;
      rem_q <= TMR_RST;
      pre_q <= '0;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      rem_q <= rem_d;
      pre_q <= pre_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule

// file: logic/dpmc_axil.sv
`timescale 1ns/10ps
module dpmc_axil
  import dpmc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register side
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_q, aw_d, w_q, w_d, ar_q, ar_d;
  logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
  logic bv_q, bv_d, rv_q, rv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [ADDR_W-1:0] wa_q, wa_d, ra_q, ra_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;

  // address and data are held separately so either may come first
  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    ar_d = ar_q;
    wa_d = wa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    ra_d = ra_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (awvalid && awr_q)
    begin
      aw_d = 1'b1;
      wa_d = awaddr;
    end
    if (wvalid && wr_q)
    begin
      w_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    wr_en = aw_q && w_q && !bv_q;
    if (wr_en)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (bv_q && bready)
      bv_d = 1'b0;
    if (arvalid && arr_q)
    begin
      ar_d = 1'b1;
      ra_d = araddr;
    end
    rd_en = ar_q && !rv_q;
    if (rd_en)
    begin
      ar_d = 1'b0;
      rv_d = 1'b1;
      rd_d = rd_data;
      rr_d = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rv_q && rready)
      rv_d = 1'b0;
    awr_d = !aw_d && !bv_d;
    wr_d = !w_d && !bv_d;
    arr_d = !ar_d && !rv_d;
  end

  // channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_q, w_q, ar_q, awr_q, wr_q, arr_q, bv_q, rv_q} <= 8'h00;
      br_q <= RESP_OKAY;
      rr_q <= RESP_OKAY;
      wa_q <= '0;
      ra_q <= '0;
      wd_q <= 32'h0000_0000;
      rd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end
    else
    begin
      {aw_q, w_q, ar_q, awr_q, wr_q, arr_q, bv_q, rv_q} <=
        {aw_d, w_d, ar_d, awr_d, wr_d, arr_d, bv_d, rv_d};
      br_q <= br_d;
      rr_q <= rr_d;
      wa_q <= wa_d;
      ra_q <= ra_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      ws_q <= ws_d;
    end
  end

  assign awready = awr_q;
  assign wready = wr_q;
  assign arready = arr_q;
  assign bvalid = bv_q;
  assign bresp = br_q;
  assign rvalid = rv_q;
  assign rdata = rd_q;
  assign rresp = rr_q;
  assign wr_addr = wa_q;
  assign wr_data = wd_q;
  assign wr_strb = ws_q;
  assign rd_addr = ra_q;
endmodule

// file: logic/dpmc_top.sv
`timescale 1ns/10ps
module dpmc_top
  import dpmc_pkg::*;
#(
  parameter int unsigned UNIT_CYC = TMR_UNIT_CYC
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // link and drive events
  input wire logic comreset,
  input wire logic puis_strap,
  input wire logic media_req,
  input wire logic idle_unload_req,
  input wire logic seek_start,
  input wire logic seek_settled,
  // mechanics handshake
  input wire logic flush_done,
  input wire logic unload_done,
  input wire logic spindle_stopped,
  input wire logic spin_ready,
  input wire logic post_done,
  output logic flush_req,
  output logic head_unload_step,
  output logic spindle_brake,
  output logic spin_up,
  output logic post_req,
  // status flags
  output logic busy_flag,
  output logic drive_ready_flag,
  output logic seek_complete_flag,
  output logic iface_active,
  output logic media_active,
  output logic cmd_done
);
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic wr_en, wr_err, rd_en, rd_err;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  dpmc_axil u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .wr_err(wr_err), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  dpmc_state_t st_q, st_d;
  logic pend_q, pend_d, to_sleep_q, to_sleep_d, by_cmd_q, by_cmd_d;
  logic seek_q, seek_d, unl_q, unl_d, tmr_en_q, tmr_en_d;
  logic [7:0] code_q, code_d, arg_q, arg_d, chk_q, chk_d;
  logic [1:0] mode_q, mode_d;
  logic busy_q, busy_d, rdy_q, rdy_d, ifc_q, ifc_d, med_q, med_d;
  logic fl_q, fl_d, ul_q, ul_d, br_q, br_d, su_q, su_d, pp_q, pp_d;
  logic done_q, done_d;
  logic tmr_load, tmr_run, tmr_exp, soft_rst, any_rst;
  logic [7:0] tmr_cnt;
  logic wr_hit;

  dpmc_tmr #(.UNIT_CYC(UNIT_CYC)) u_tmr (
    .aclk(aclk), .aresetn(aresetn), .load(tmr_load),
    .count(tmr_cnt), .run(tmr_run), .expired(tmr_exp)
  );

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // low two address bits are ignored, every register is one word
  always_comb
  begin
    wr_hit = wr_en && wr_strb[0];
    wr_err = !(wr_addr[4:2] inside {OFF_CTRL[4:2], OFF_CMD[4:2], OFF_TMR[4:2],
                                    OFF_STATUS[4:2], OFF_CHECK[4:2]});
    rd_err = 1'b0;
    rd_data = 32'h0000_0000;
    unique case (rd_addr[4:2])
      OFF_CTRL[4:2]: rd_data = 32'h0000_0000;
      OFF_CMD[4:2]: rd_data[8:0] = {pend_q, code_q};
      OFF_TMR[4:2]: rd_data[7:0] = arg_q;
      OFF_STATUS[4:2]:
      begin
        rd_data[SB_BUSY] = busy_q;
        rd_data[SB_READY] = rdy_q;
        rd_data[SB_SEEK] = seek_q;
        rd_data[SB_IFACE] = ifc_q;
        rd_data[SB_MEDIA] = med_q;
        rd_data[SB_UNLOADED] = unl_q;
        rd_data[SB_TIMER] = tmr_en_q;
        rd_data[SB_MODE+:2] = mode_q;
      end
      OFF_CHECK[4:2]: rd_data[7:0] = chk_q;
      default: rd_err = 1'b1;
    endcase
    soft_rst = wr_hit && (wr_addr[4:2] == OFF_CTRL[4:2]) && wr_data[CTRL_SOFT_RST];
    any_rst = soft_rst || comreset;
  end

  // ----------------------------------------
  // power-mode sequencer
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    pend_d = pend_q;
    code_d = code_q;
    arg_d = arg_q;
    chk_d = chk_q;
    to_sleep_d = to_sleep_q;
    by_cmd_d = by_cmd_q;
    seek_d = seek_q;
    unl_d = unl_q;
    tmr_en_d = tmr_en_q;
    tmr_load = 1'b0;
    tmr_cnt = arg_q;
    done_d = 1'b0;
    if (wr_hit && (wr_addr[4:2] == OFF_TMR[4:2]))
      arg_d = wr_data[7:0];
    // commands are taken only while awake and no command is pending
    if (wr_hit && (wr_addr[4:2] == OFF_CMD[4:2]) && !pend_q && st_q != ST_SLEEP)
    begin
      pend_d = 1'b1;
      code_d = wr_data[7:0];
    end
    if (seek_start)
      seek_d = 1'b0;
    else if (seek_settled)
      seek_d = 1'b1;
    // a check is served at once in every state but ST_FLAGS, so that transitions can be reported
    if (pend_q && code_q == CMD_CHECK && st_q != ST_FLAGS)
    begin
      pend_d = 1'b0;
      done_d = 1'b1;
      unique case (st_q)
        ST_ACTIVE: chk_d = CHK_ACTIVE;
        ST_IDLE, ST_IUNLOAD, ST_BOOT: chk_d = CHK_IDLE;
        ST_STBY, ST_SLEEP: chk_d = CHK_STBY;
        ST_SPINUP: chk_d = CHK_FROM_STBY;
        default: chk_d = CHK_TO_STBY;
      endcase
    end
    unique case (st_q)
      ST_BOOT: st_d = puis_strap ? ST_STBY : ST_IDLE;
      ST_IDLE, ST_STBY, ST_ACTIVE:
      begin
        if (pend_q && code_q != CMD_CHECK)
        begin
          pend_d = 1'b0;
          if (code_q == CMD_IDLE || code_q == CMD_IDLE_IMM)
          begin
            st_d = ST_IDLE;
            done_d = 1'b1;
            if (code_q == CMD_IDLE)
            begin
              tmr_load = 1'b1;
              tmr_en_d = 1'b1;
            end
          end
          else if (code_q inside {CMD_STBY, CMD_STBY_IMM, CMD_SLEEP})
          begin
            st_d = (st_q == ST_STBY && code_q != CMD_SLEEP) ? ST_STBY : ST_FLUSH;
            done_d = (st_d == ST_STBY);
            to_sleep_d = (code_q == CMD_SLEEP);
            by_cmd_d = 1'b1;
            tmr_load = (code_q == CMD_STBY);
          end
          else
            done_d = 1'b1;
        end
        else if (st_q == ST_ACTIVE)
        begin
          if (!media_req)
            st_d = ST_IDLE;
        end
        else if (st_q == ST_STBY)
        begin
          if (media_req)
            st_d = ST_SPINUP;
        end
        else if (media_req)
          st_d = ST_ACTIVE;
        else if (tmr_exp)
        begin
          st_d = ST_FLUSH;
          to_sleep_d = 1'b0;
          by_cmd_d = 1'b0;
        end
        else if (idle_unload_req && !unl_q)
          st_d = ST_IUNLOAD;
      end
      ST_SPINUP: if (spin_ready) st_d = ST_ACTIVE;
      ST_IUNLOAD:
      begin
        if (unload_done)
        begin
          unl_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_FLUSH: if (flush_done) st_d = ST_UNLOAD;
      ST_UNLOAD:
      begin
        if (unload_done)
        begin
          unl_d = 1'b1;
          st_d = ST_FLAGS;
        end
      end
      ST_FLAGS:
      begin
        seek_d = 1'b1;
        done_d = by_cmd_q;
        st_d = ST_BRAKE;
      end
      ST_BRAKE: st_d = ST_SPIN_WAIT;
      ST_SPIN_WAIT: if (spindle_stopped) st_d = ST_POST;
      ST_POST: if (post_done) st_d = to_sleep_q ? ST_SLEEP : ST_STBY;
      ST_SLEEP: if (any_rst) st_d = ST_STBY;
    endcase
    if (st_d == ST_ACTIVE)
      unl_d = 1'b0;
    if (st_d == ST_STBY || st_d == ST_SLEEP)
      seek_d = 1'b1;
    // link reset keeps the mode outside sleep, but clears and stops the standby timer count
    if (comreset)
    begin
      tmr_load = 1'b1;
      tmr_cnt = TMR_RST;
      tmr_en_d = 1'b0;
    end
    tmr_run = tmr_en_q && st_q == ST_IDLE && !pend_q;
  end

  // ----------------------------------------
  // registered flags and mechanics strobes
  // ----------------------------------------
  // decoded from the next state so outputs line up with it
  always_comb
  begin
    busy_d = pend_d || st_d inside {ST_FLUSH, ST_UNLOAD, ST_SPINUP, ST_BOOT};
    rdy_d = st_d != ST_SLEEP;
    ifc_d = st_d != ST_SLEEP;
    med_d = st_d inside {ST_ACTIVE, ST_IDLE, ST_IUNLOAD};
    fl_d = st_d == ST_FLUSH;
    ul_d = st_d inside {ST_UNLOAD, ST_IUNLOAD};
    br_d = st_d inside {ST_BRAKE, ST_SPIN_WAIT};
    su_d = st_d == ST_SPINUP;
    pp_d = st_d == ST_POST;
    unique case (st_d)
      ST_ACTIVE, ST_SPINUP: mode_d = MODE_ACTIVE;
      ST_IDLE, ST_IUNLOAD, ST_BOOT: mode_d = MODE_IDLE;
      ST_SLEEP: mode_d = MODE_SLEEP;
      default: mode_d = MODE_STBY;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_BOOT;
      {pend_q, to_sleep_q, by_cmd_q, seek_q, unl_q, tmr_en_q} <= 6'h00;
      code_q <= 8'h00;
      arg_q <= TMR_RST;
      chk_q <= CHK_RST;
      mode_q <= MODE_IDLE;
      {busy_q, rdy_q, ifc_q, med_q, done_q} <= 5'h00;
      {fl_q, ul_q, br_q, su_q, pp_q} <= 5'h00;
    end
    else
    begin
      st_q <= st_d;
      {pend_q, to_sleep_q, by_cmd_q, seek_q, unl_q, tmr_en_q} <=
        {pend_d, to_sleep_d, by_cmd_d, seek_d, unl_d, tmr_en_d};
      code_q <= code_d;
      arg_q <= arg_d;
      chk_q <= chk_d;
      mode_q <= mode_d;
      {busy_q, rdy_q, ifc_q, med_q, done_q} <= {busy_d, rdy_d, ifc_d, med_d, done_d};
      {fl_q, ul_q, br_q, su_q, pp_q} <= {fl_d, ul_d, br_d, su_d, pp_d};
    end
  end

  assign flush_req = fl_q;
  assign head_unload_step = ul_q;
  assign spindle_brake = br_q;
  assign spin_up = su_q;
  assign post_req = pp_q;
  assign busy_flag = busy_q;
  assign drive_ready_flag = rdy_q;
  assign seek_complete_flag = seek_q;
  assign iface_active = ifc_q;
  assign media_active = med_q;
  assign cmd_done = done_q;
endmodule

// file: tb/dpmc_top_monitor.sv
`timescale 1ns/10ps
module dpmc_top_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic comreset,
  // mechanics strobes
  input wire logic flush_req,
  input wire logic head_unload_step,
  input wire logic spindle_brake,
  input wire logic spin_up,
  input wire logic post_req,
  // status flags
  input wire logic drive_ready_flag,
  input wire logic seek_complete_flag,
  input wire logic iface_active,
  input wire logic media_active,
  input wire logic cmd_done
);
  // one domain, so clock and reset are given once for all properties
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // completion only once the heads are parked and the flush is over
  a_done_after_unload: assert property (cmd_done |-> !head_unload_step && !flush_req)
    else $error("command completed while unload or flush still running");
  a_unload_alone: assert property (head_unload_step |->
    !flush_req && !spindle_brake && !post_req)
    else $error("head unload overlaps another mechanics step");
  a_brake_after_flags: assert property ($rose(spindle_brake) |->
    seek_complete_flag && drive_ready_flag && !head_unload_step)
    else $error("spindle brake began before flags were set");
  a_post_after_stop: assert property ($rose(post_req) |->
    !spindle_brake && $past(spindle_brake))
    else $error("post processing did not follow the spindle stop");
  a_ready_when_awake: assert property (iface_active |-> drive_ready_flag)
    else $error("ready flag low with interface active");
  a_sleep_media_off: assert property (!iface_active |-> !media_active)
    else $error("media active with interface inactive");
  a_spinup_no_media: assert property (spin_up |-> !media_active)
    else $error("media access before spindle at speed");
  a_sleep_after_post: assert property ($fell(iface_active) |-> $past(post_req))
    else $error("interface went inactive without post processing");
  a_wake_on_reset: assert property (!iface_active && comreset |->
    ##[1:3] iface_active)
    else $error("link reset did not wake the sleeping device");
endmodule

bind dpmc_top dpmc_top_monitor mon_u (.*);

// file: tb/dpmc_mech.sv
`timescale 1ns/10ps
module dpmc_mech (
  // clock, reset and pacing
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] lat,
  // step requests from the sequencer
  input wire logic flush_req,
  input wire logic head_unload_step,
  input wire logic spindle_brake,
  input wire logic spin_up,
  input wire logic post_req,
  // step acknowledges
  output logic flush_done,
  output logic unload_done,
  output logic spindle_stopped,
  output logic spin_ready,
  output logic post_done
);
  logic [4:0] req;
  logic [4:0] ack;
  logic [3:0] cnt_q [5];
  logic [3:0] cnt_d [5];

  assign req = {post_req, spin_up, spindle_brake, head_unload_step, flush_req};
  // each step ends lat cycles after it is asked for; saturating so long waits do not wrap
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      cnt_d[i] = !req[i] ? 4'h0 : (cnt_q[i] == 4'hf) ? cnt_q[i] : cnt_q[i] + 4'h1;
      ack[i] = req[i] && (cnt_q[i] >= lat);
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '{default: 4'h0};
    else
      cnt_q <= cnt_d;
  end
  // acks fall with their request, so a stale ack never ends a later step
  assign {post_done, spin_ready, spindle_stopped, unload_done, flush_done} = ack;
endmodule

// file: tb/test_drive_power_mode_controller.sv
`timescale 1ns/10ps
module test_drive_power_mode_controller;
  import dpmc_pkg::*;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, comreset, puis_strap;
  logic media_req, idle_unload_req, seek_start, seek_settled, awready, wready, bvalid;
  logic arready, rvalid, flush_done, unload_done, spindle_stopped, spin_ready, post_done;
  logic flush_req, head_unload_step, spindle_brake, spin_up, post_req, busy_flag;
  logic drive_ready_flag, seek_complete_flag, iface_active, media_active, cmd_done;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb, lat;
  logic [1:0] bresp, rresp, r;
  logic hu_seen = 1'b0;
  logic spun = 1'b0;
  int fails = 0;
  int total_checks = 0;
  int dones = 0;

  // short timer unit keeps the standby countdown to a few cycles
  dpmc_top #(.UNIT_CYC(4)) dut_u (.*);
  dpmc_mech mech_u (.*);

  // 125 MHz
  initial
  begin
    forever #4 aclk = ~aclk;
  end
  // completion pulses, head unload and spin-up steps are seen here, never missed by a busy task
  always @(posedge aclk)
  begin
    if (cmd_done === 1'b1) dones++;
    if (head_unload_step === 1'b1) hu_seen = 1'b1;
    if (spin_up === 1'b1) spun = 1'b1;
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bready and rready stay high throughout, so responses are taken on arrival
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask
  // a command goes out only while busy is clear, then waits for its completion
  task automatic cmd(input logic [7:0] c);
    int d0;
    while (busy_flag !== 1'b0) @(posedge aclk);
    d0 = dones;
    wr(OFF_CMD, {24'h0, c});
    while (dones == d0) @(posedge aclk);
  endtask
  task automatic want_mode(input logic [1:0] m);
    int n;
    n = 0;
    do
    begin
      rd(OFF_STATUS);
      n++;
    end while (v[SB_MODE+:2] !== m && n < 60);
    chk(v[SB_MODE+:2], m);
  endtask
  task automatic check_answer(input logic [7:0] e);
    cmd(CMD_CHECK);
    rd(OFF_CHECK);
    chk(v[7:0], e);
  endtask
  task automatic do_reset(input logic strap);
    aresetn <= 1'b0;
    puis_strap <= strap;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {awvalid, wvalid, arvalid, comreset, media_req, idle_unload_req, seek_start} <= '0;
    {seek_settled, awaddr, araddr, wdata} <= '0;
    {bready, rready, wstrb, lat} <= {2'h3, 4'hf, 4'h1};
    do_reset(1'b0);
    want_mode(MODE_IDLE);
    chk({v[SB_MEDIA], v[SB_IFACE], v[SB_READY], v[SB_BUSY]}, 4'he);
    rd(5'h1c);
    chk(r, RESP_SLVERR);
    chk(v, 32'h0);
    wr(5'h14, 32'h0);
    chk(r, RESP_SLVERR);
    check_answer(CHK_IDLE);
    seek_start <= 1'b1;
    @(posedge aclk);
    seek_start <= 1'b0;
    rd(OFF_STATUS);
    chk(v[SB_SEEK], 1'b0);
    seek_settled <= 1'b1;
    @(posedge aclk);
    seek_settled <= 1'b0;
    rd(OFF_STATUS);
    chk(v[SB_SEEK], 1'b1);
    // idle unload with no host command, mode stays idle
    idle_unload_req <= 1'b1;
    @(posedge aclk);
    idle_unload_req <= 1'b0;
    repeat (20) @(posedge aclk);
    chk(hu_seen, 1'b1);
    want_mode(MODE_IDLE);
    media_req <= 1'b1;
    want_mode(MODE_ACTIVE);
    check_answer(CHK_ACTIVE);
    media_req <= 1'b0;
    want_mode(MODE_IDLE);
    // slow mechanics: completion must still wait for the unload
    lat <= 4'h5;
    hu_seen = 1'b0;
    cmd(CMD_STBY_IMM);
    chk(hu_seen, 1'b1);
    // the brake and post steps are still running, so the answer is entering standby
    check_answer(CHK_TO_STBY);
    while (post_req !== 1'b0) @(posedge aclk);
    want_mode(MODE_STBY);
    chk({v[SB_SEEK], v[SB_MEDIA], v[SB_IFACE], v[SB_READY], v[SB_BUSY]}, 5'h16);
    chk({seek_complete_flag, media_active, iface_active, drive_ready_flag, busy_flag}, 5'h16);
    check_answer(CHK_STBY);
    lat <= 4'h1;
    cmd(CMD_IDLE_IMM);
    want_mode(MODE_IDLE);
    wr(OFF_TMR, 32'h2);
    chk(r, RESP_OKAY);
    rd(OFF_TMR);
    chk(v[7:0], 8'h02);
    cmd(CMD_IDLE);
    want_mode(MODE_STBY);
    spun = 1'b0;
    media_req <= 1'b1;
    want_mode(MODE_ACTIVE);
    chk(spun, 1'b1);
    media_req <= 1'b0;
    // sleep, woken once by link reset and once by soft reset
    for (int k = 0; k < 2; k++)
    begin
      cmd(CMD_SLEEP);
      while (iface_active !== 1'b0) @(posedge aclk);
      chk(media_active, 1'b0);
      if (k == 0)
      begin
        comreset <= 1'b1;
        @(posedge aclk);
        comreset <= 1'b0;
      end
      else
        wr(OFF_CTRL, 32'h1);
      repeat (4) @(posedge aclk);
      chk(iface_active, 1'b1);
      want_mode(MODE_STBY);
    end
    cmd(CMD_IDLE_IMM);
    comreset <= 1'b1;
    @(posedge aclk);
    comreset <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(OFF_STATUS);
    chk(v[SB_MODE+:2], MODE_IDLE);
    do_reset(1'b1);
    want_mode(MODE_STBY);
    finish_test;
  end

  // hang guard, well beyond the expected run of a few hundred cycles
  initial
  begin
    #400us;
    fails++;
    finish_test;
  end
endmodule
